/* File: design/uefc_pkg.sv */
// constants and carriers for the uart enhanced feature control block
// ============================================================
// Notes on behaviour
// - send-immediately moves one byte, then self-clears
// - direction output polarity follows invert bit
// - error interrupt at holding register or fifo entry
// - clear mode 0: read, resume or next char clears
// - clear mode 1: only status read clears flags
// - divisor is high:low plus fraction over sixteen
// - separate tx/rx sets; fraction needs enhanced enable
// - sampling 16x, 8x, or 4x when upper bit set
// - independent bit selects shared or separate generators
// - select bit steers divisor writes to tx or rx
// - shared with select set: divisor writes ignored
// - level count shows rx or tx fifo count
// - swap: scratchpad reads count, writes mode select
// - level count readable when line control is 0xBF
// - receive inversion flips encoded ir input idle
// - auto direction off: interrupt on holding empty
// - direction rises bit after last stop, falls on load
// - auto direction on: interrupt waits for shifter empty
// - dual flow characters matched as two-char sequence
// - enhanced enable gates and latches fraction control bits
package uefc_pkg;
  // ============================================================
  // register addresses (3-bit parallel bus)
  localparam logic [2:0] ADDR_DIV_LOW  = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
  localparam logic [2:0] ADDR_DIV_FRAC = 3'h2;
  localparam logic [2:0] ADDR_FEATURE  = 3'h1;
  localparam logic [2:0] ADDR_ENH_FEAT = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTL = 3'h3;
  localparam logic [2:0] ADDR_SCRATCH  = 3'h7;
  localparam logic [7:0] LCR_ENH_KEY   = 8'hBF;
  // ============================================================
  // field positions
  localparam int EMS_SEND_NOW  = 2;
  localparam int EMS_DIR_INV   = 3;
  localparam int EMS_LSR_IMM   = 6;
  localparam int EMS_CLR_MODE  = 7;
  localparam int FCT_IR_INV    = 2;
  localparam int FCT_AUTO_DIR  = 3;
  localparam int FCT_SWAP      = 6;
  localparam int FCT_CNT_TX    = 7;
  localparam int EFR_ENH_EN    = 4;
  localparam int DLD_INDEP     = 6;
  localparam int DLD_SEL_RX    = 7;
  localparam int LCR_DLAB      = 7;
  // ============================================================
  // reset values
  localparam logic [7:0] RST_SCRATCH = 8'hFF;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [5:0] RST_BIT_CNT = 6'h00;
  // ============================================================
  // sampling rates (clocks per bit)
  localparam logic [4:0] SAMP_16X = 5'h10;
  localparam logic [4:0] SAMP_8X  = 5'h08;
  localparam logic [4:0] SAMP_4X  = 5'h04;

  // one baud generator setting
  typedef struct packed {
    logic [7:0] div_high;
    logic [7:0] div_low;
    logic [5:0] frac;
  } uefc_brg_s;

  // events from the core transmitter and receiver
  typedef struct packed {
    logic rx_err_fifo;
    logic rx_err_head;
    logic rx_char;
    logic rx_resume;
    logic rx_pause;
    logic rx_special;
    logic tx_load;
    logic thr_empty;
    logic tsr_empty;
    logic bit_tick;
  } uefc_evt_s;

  typedef enum logic [1:0] {
    DIR_RX   = 2'b00,
    DIR_TX   = 2'b01,
    DIR_HOLD = 2'b10
  } uefc_dir_e;
endpackage

/* File: design/uefc_top.sv */
// enhanced feature control logic of the fifo uart
`timescale 1ns/1ps
`default_nettype none
module uefc_top
  import uefc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  // host parallel bus
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       isr_rd_i,
  output logic      [7:0] rdata_o,
  // core status
  input  wire uefc_evt_s  evt_i,
  input  wire logic       fifo_en_i,
  input  wire logic [5:0] rx_count_i,
  input  wire logic [5:0] tx_count_i,
  input  wire logic       rx_pin_i,
  input  wire logic       rx_second_i,
  // outputs to core and line
  output uefc_brg_s       tx_brg_o,
  output uefc_brg_s       rx_brg_o,
  output logic [4:0]      tx_samp_o,
  output logic [4:0]      rx_samp_o,
  output logic            send_now_o,
  output logic            ir_rx_o,
  output logic            dir_n_o,
  output logic            tx_irq_o,
  output logic            lsr_irq_o,
  output logic            pause_irq_o,
  output logic            resume_irq_o,
  output logic            special_irq_o,
  output logic            seq_pause_o,
  output logic            seq_resume_o
);

  // sampling field decode, shared by both generators
  function automatic logic [4:0] samp_of(input logic [5:0] f);
    // upper bit alone picks 4x, the lower bit is then ignored
    if (f[5]) begin
      samp_of = SAMP_4X;
    end else if (f[4]) begin
      samp_of = SAMP_8X;
    end else begin
      samp_of = SAMP_16X;
    end
  endfunction

  // ============================================================
  // register state
  logic [7:0] line_ctl, scratch, ems, fct, enhanced_feature, dld_ctl;
  logic [7:0] next_line_ctl, next_scratch, next_ems, next_fct, next_efr, next_dld_ctl;
  uefc_brg_s  tx_brg, rx_brg, next_tx_brg, next_rx_brg;
  logic       dlab, enh_key, enh_en;
  logic       send_armed, next_send_armed;

  // the unlock value outranks the divisor latch bit it also contains
  assign dlab    = line_ctl[LCR_DLAB];
  assign enh_key = (line_ctl == LCR_ENH_KEY);
  assign enh_en  = enhanced_feature[EFR_ENH_EN];

  // register writes; fraction control bits hold while enable is low
  always_comb begin
    logic wsel_tx, wsel_rx;
    wsel_tx = 1'b0;
    wsel_rx = 1'b0;
    next_line_ctl = line_ctl;
    next_scratch  = scratch;
    next_ems      = ems;
    next_fct      = fct;
    next_efr      = enhanced_feature;
    next_dld_ctl  = dld_ctl;
    next_tx_brg   = tx_brg;
    next_rx_brg   = rx_brg;
    // generator steering on the current select bits; a fraction
    // write therefore never redirects itself, only later writes
    if (!dld_ctl[DLD_INDEP]) begin
      wsel_tx = !dld_ctl[DLD_SEL_RX];
      wsel_rx = !dld_ctl[DLD_SEL_RX];
    end else begin
      wsel_tx = !dld_ctl[DLD_SEL_RX];
      wsel_rx = dld_ctl[DLD_SEL_RX];
    end
    // self-clear once the immediate byte left the shifter; the core
    // reports empty only when holding and shift side are both idle,
    // so the bit cannot drop between the load and the first shift
    if (ems[EMS_SEND_NOW] && evt_i.tsr_empty && evt_i.tx_load == 1'b0 && send_armed) begin
      next_ems[EMS_SEND_NOW] = 1'b0;
    end
    if (wr_i) begin
      if (addr_i == ADDR_LINE_CTL) begin
        next_line_ctl = wdata_i;
      end else if (addr_i == ADDR_SCRATCH) begin
        if (fct[FCT_SWAP]) begin
          next_ems = wdata_i;
        end else begin
          next_scratch = wdata_i;
        end
      end else if (enh_key && addr_i == ADDR_ENH_FEAT) begin
        next_efr = wdata_i; // flow selection bits stored as written
      end else if (enh_key && addr_i == ADDR_FEATURE) begin
        next_fct = wdata_i;
      end else if (dlab && !enh_key && addr_i == ADDR_DIV_LOW) begin
        if (wsel_tx) next_tx_brg.div_low = wdata_i;
        if (wsel_rx) next_rx_brg.div_low = wdata_i;
      end else if (dlab && !enh_key && addr_i == ADDR_DIV_HIGH) begin
        if (wsel_tx) next_tx_brg.div_high = wdata_i;
        if (wsel_rx) next_rx_brg.div_high = wdata_i;
      end else if (dlab && !enh_key && addr_i == ADDR_DIV_FRAC && enh_en) begin
        next_dld_ctl = wdata_i;
        if (wsel_tx) next_tx_brg.frac = wdata_i[5:0];
        if (wsel_rx) next_rx_brg.frac = wdata_i[5:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      line_ctl <= RST_ZERO;
      scratch  <= RST_SCRATCH;
      ems      <= RST_ZERO;
      fct      <= RST_ZERO;
      enhanced_feature      <= RST_ZERO;
      dld_ctl  <= RST_ZERO;
      tx_brg   <= '{div_high: RST_ZERO, div_low: RST_DIV_LOW, frac: 6'h00};
      rx_brg   <= '{div_high: RST_ZERO, div_low: RST_DIV_LOW, frac: 6'h00};
    end else begin
      line_ctl <= next_line_ctl;
      scratch  <= next_scratch;
      ems      <= next_ems;
      fct      <= next_fct;
      enhanced_feature      <= next_efr;
      dld_ctl  <= next_dld_ctl;
      tx_brg   <= next_tx_brg;
      rx_brg   <= next_rx_brg;
    end
  end

  // ============================================================
  // send-immediately tracking: armed once the byte is loaded
  // disarming with the fifo off keeps a stale arm from clearing a later set
  always_comb begin
    next_send_armed = send_armed;
    if (!ems[EMS_SEND_NOW] || !fifo_en_i) begin
      next_send_armed = 1'b0;
    end else if (evt_i.tx_load) begin
      next_send_armed = 1'b1;
    end
  end

  // ============================================================
  // read path; count location wins over scratchpad when swapped
  // unmapped reads return zero so no stale byte lingers on the bus
  logic [7:0] next_rdata, level;
  assign level = fct[FCT_CNT_TX] ? {2'b00, tx_count_i} : {2'b00, rx_count_i};
  always_comb begin
    next_rdata = RST_ZERO;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_SCRATCH: next_rdata = (fct[FCT_SWAP] || enh_key) ? level : scratch;
        ADDR_LINE_CTL: next_rdata = line_ctl;
        ADDR_DIV_LOW: next_rdata = dlab ? (dld_ctl[DLD_SEL_RX] ? rx_brg.div_low : tx_brg.div_low) : RST_ZERO;
        ADDR_DIV_HIGH: next_rdata = enh_key ? fct
                                  : (dld_ctl[DLD_SEL_RX] ? rx_brg.div_high : tx_brg.div_high);
        ADDR_DIV_FRAC: next_rdata = enh_key ? enhanced_feature : dld_ctl;
        default: next_rdata = RST_ZERO;
      endcase
    end
  end

  // ============================================================
  // interrupt flag management
  logic lsr_f, pause_f, resume_f, special_f;
  logic next_lsr_f, next_pause_f, next_resume_f, next_special_f;
  always_comb begin
    logic err_ev, clr_mode0;
    // immediate mode fires at fifo entry, delayed at holding register
    err_ev    = ems[EMS_LSR_IMM] ? evt_i.rx_err_fifo : evt_i.rx_err_head;
    clr_mode0 = !ems[EMS_CLR_MODE];
    next_lsr_f = lsr_f;
    next_pause_f = pause_f;
    next_resume_f = resume_f;
    next_special_f = special_f;
    if (isr_rd_i) begin
      next_lsr_f = 1'b0;
      next_pause_f = 1'b0;
      next_resume_f = 1'b0;
      next_special_f = 1'b0;
    end
    // mode 1 keeps pause and special until the status read
    if (clr_mode0 && evt_i.rx_resume) next_pause_f = 1'b0;
    if (clr_mode0 && evt_i.rx_char) next_special_f = 1'b0;
    // sets win over any clear in the same cycle
    if (err_ev) next_lsr_f = 1'b1;
    if (evt_i.rx_pause) next_pause_f = 1'b1;
    if (evt_i.rx_resume) next_resume_f = 1'b1;
    if (evt_i.rx_special) next_special_f = 1'b1;
  end

  // ============================================================
  // dual character sequence matcher
  // a first half not followed at once by its partner is dropped
  logic pause_half, resume_half, next_pause_half, next_resume_half;
  logic next_seq_pause, next_seq_resume;
  always_comb begin
    next_pause_half  = pause_half;
    next_resume_half = resume_half;
    next_seq_pause   = 1'b0;
    next_seq_resume  = 1'b0;
    if (evt_i.rx_char) begin
      next_seq_pause  = pause_half && evt_i.rx_pause && rx_second_i;
      next_seq_resume = resume_half && evt_i.rx_resume && rx_second_i;
      next_pause_half  = evt_i.rx_pause && !rx_second_i;
      next_resume_half = evt_i.rx_resume && !rx_second_i;
    end
  end

  // ============================================================
  // direction control and transmit interrupt
  uefc_dir_e dir_st, next_dir_st;
  logic      tx_irq_n, next_dir_n;
  always_comb begin
    next_dir_st = dir_st;
    unique case (dir_st)
      DIR_RX:   if (evt_i.tx_load) next_dir_st = DIR_TX;
      DIR_TX:   if (evt_i.tsr_empty) next_dir_st = DIR_HOLD;
      DIR_HOLD: begin
        // a new byte cancels the turnaround before it happens
        if (evt_i.tx_load) begin
          next_dir_st = DIR_TX;
        end else if (evt_i.bit_tick) begin
          next_dir_st = DIR_RX;
        end
      end
      default:  next_dir_st = DIR_RX;
    endcase
    if (!fct[FCT_AUTO_DIR]) next_dir_st = DIR_RX;
    tx_irq_n = fct[FCT_AUTO_DIR] ? evt_i.tsr_empty : evt_i.thr_empty;
    // transmit and turnaround drive low unless the polarity is inverted
    if (next_dir_st != DIR_RX) begin
      next_dir_n = ems[EMS_DIR_INV];
    end else begin
      next_dir_n = !ems[EMS_DIR_INV];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      send_armed    <= 1'b0;
      rdata_o       <= RST_ZERO;
      lsr_f         <= 1'b0;
      pause_f       <= 1'b0;
      resume_f      <= 1'b0;
      special_f     <= 1'b0;
      pause_half    <= 1'b0;
      resume_half   <= 1'b0;
      seq_pause_o   <= 1'b0;
      seq_resume_o  <= 1'b0;
      dir_st        <= DIR_RX;
      dir_n_o       <= 1'b1;
      tx_irq_o      <= 1'b0;
      ir_rx_o       <= 1'b0;
      tx_brg_o      <= '0;
      rx_brg_o      <= '0;
      tx_samp_o     <= SAMP_16X;
      rx_samp_o     <= SAMP_16X;
      send_now_o    <= 1'b0;
    end else begin
      send_armed    <= next_send_armed;
      rdata_o       <= next_rdata;
      lsr_f         <= next_lsr_f;
      pause_f       <= next_pause_f;
      resume_f      <= next_resume_f;
      special_f     <= next_special_f;
      pause_half    <= next_pause_half;
      resume_half   <= next_resume_half;
      seq_pause_o   <= next_seq_pause;
      seq_resume_o  <= next_seq_resume;
      dir_st        <= next_dir_st;
      // low level = transmit when not inverted
      dir_n_o       <= next_dir_n;
      tx_irq_o      <= tx_irq_n;
      ir_rx_o       <= rx_pin_i ^ fct[FCT_IR_INV];
      tx_brg_o      <= next_tx_brg;
      rx_brg_o      <= next_rx_brg;
      tx_samp_o     <= samp_of(next_tx_brg.frac);
      rx_samp_o     <= samp_of(next_rx_brg.frac);
      send_now_o    <= next_ems[EMS_SEND_NOW] && fifo_en_i;
    end
  end

  // flags drive the outputs directly from their flops
  // levels, not pulses: a flag stays until its clear arrives
  assign lsr_irq_o     = lsr_f;
  assign pause_irq_o   = pause_f;
  assign resume_irq_o  = resume_f;
  assign special_irq_o = special_f;

endmodule // uefc_top
`default_nettype wire

/* File: test/uefc_asserts.sv */
// assertion checker for the enhanced feature control block
`timescale 1ns/1ps
`default_nettype none
module uefc_asserts
  import uefc_pkg::*;
(
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       rstn_i,
  // host bus
  input wire logic [2:0] addr_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic       isr_rd_i,
  input wire logic [7:0] rdata_o,
  // core and line
  input wire uefc_evt_s  evt_i,
  input wire logic       rx_pin_i,
  input wire uefc_brg_s  tx_brg_o,
  input wire logic       ir_rx_o,
  input wire logic       lsr_irq_o,
  input wire logic       pause_irq_o,
  input wire logic       resume_irq_o,
  input wire logic       special_irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // ============================================================
  // bus and generator
  property p_rdata_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");
  // the depth-two reset guard skips the power-up divisor load
  property p_brg_wr; $changed(tx_brg_o.div_low) && $past(rstn_i, 2) |-> $past(wr_i) && $past(addr_i) == ADDR_DIV_LOW;
  endproperty
  a_brg_wr: assert property (p_brg_wr) else $error("divisor moved without a write");
  // inversion is steady unless a write landed one cycle before
  property p_ir_follow; $changed(rx_pin_i) && !$past(wr_i) |=> $changed(ir_rx_o); endproperty
  a_ir_follow: assert property (p_ir_follow) else $error("ir output ignored the pin");
  // ============================================================
  // interrupt flags
  property p_pause_set; $rose(pause_irq_o) |-> $past(evt_i.rx_pause); endproperty
  a_pause_set: assert property (p_pause_set) else $error("pause flag without pause char");
  property p_pause_clr; $fell(pause_irq_o) |-> $past(isr_rd_i) || $past(evt_i.rx_resume); endproperty
  a_pause_clr: assert property (p_pause_clr) else $error("pause flag cleared without cause");
  property p_resume_clr; $fell(resume_irq_o) |-> $past(isr_rd_i); endproperty
  a_resume_clr: assert property (p_resume_clr) else $error("resume flag cleared without read");
  property p_spc_clr; $fell(special_irq_o) |-> $past(isr_rd_i) || $past(evt_i.rx_char); endproperty
  a_spc_clr: assert property (p_spc_clr) else $error("special flag cleared without cause");
  property p_lsr_set; $rose(lsr_irq_o) |-> $past(evt_i.rx_err_fifo) || $past(evt_i.rx_err_head); endproperty
  a_lsr_set: assert property (p_lsr_set) else $error("line status flag without error");
  // main scenarios reached
  c_pause: cover property ($rose(pause_irq_o));
  c_lsr: cover property ($rose(lsr_irq_o));
  c_spc: cover property ($fell(special_irq_o));
endmodule // uefc_asserts
bind uefc_top uefc_asserts u_chk (.mclk_i, .rstn_i, .addr_i, .wr_i, .rd_i, .isr_rd_i, .rdata_o, .evt_i,
  .rx_pin_i, .tx_brg_o, .ir_rx_o, .lsr_irq_o, .pause_irq_o, .resume_irq_o, .special_irq_o);
`default_nettype wire

/* File: test/uefc_core_model.sv */
// behavioural core transmitter and receiver facing the block
`timescale 1ns/1ps
`default_nettype none
module uefc_core_model
  import uefc_pkg::*;
#(
  parameter int BIT_CLKS = 4
)(
  // clock and reset
  input  wire logic      mclk_i,
  input  wire logic      rstn_i,
  // bench commands
  input  wire logic      load_i,
  input  wire uefc_evt_s rx_ev_i,
  // events and levels to the block
  output uefc_evt_s      evt_o,
  output logic [5:0]     tx_count_o,
  output logic [5:0]     rx_count_o
);
  logic [7:0] tick_cnt;
  logic [7:0] shift_cnt;
  logic       busy;
  assign busy = shift_cnt != 8'h00;
  // receive events pass through; transmit levels come from the queue
  always_comb begin
    evt_o           = rx_ev_i;
    evt_o.tx_load   = load_i;
    evt_o.thr_empty = tx_count_o == 6'h00;
    evt_o.tsr_empty = !busy && tx_count_o == 6'h00; // holding and shift side idle
    evt_o.bit_tick  = tick_cnt == 8'h00;
  end
  // shifter holds a byte ten bit times, so the holding side empties first
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tick_cnt   <= 8'h00;
      shift_cnt  <= 8'h00;
      tx_count_o <= 6'h00;
      rx_count_o <= 6'h00;
    end else begin
      tick_cnt   <= (tick_cnt == 8'(BIT_CLKS - 1)) ? 8'h00 : tick_cnt + 8'h01;
      rx_count_o <= rx_count_o + 6'(rx_ev_i.rx_char);
      if (!busy && tx_count_o != 6'h00) begin
        shift_cnt  <= 8'(10 * BIT_CLKS);
        tx_count_o <= tx_count_o - 6'h01 + 6'(load_i);
      end else begin
        shift_cnt  <= busy ? shift_cnt - 8'h01 : 8'h00;
        tx_count_o <= tx_count_o + 6'(load_i);
      end
    end
  end
endmodule // uefc_core_model
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the enhanced feature control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench;
  import uefc_pkg::*;
  // ============================================================
  // signals
  logic       mclk_i, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, isr_rd_i = 1'b0, load = 1'b0, rx_pin_i = 1'b1;
  logic       fifo_en_i = 1'b1;
  logic       rx_second_i = 1'b0, seq_pause_o, seq_resume_o;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic [5:0] rx_count_i, tx_count_i;
  logic [4:0] tx_samp_o, rx_samp_o;
  uefc_evt_s  evt_i, rx_ev = '0;
  uefc_brg_s  tx_brg_o, rx_brg_o;
  logic       send_now_o, ir_rx_o, dir_n_o, tx_irq_o, lsr_irq_o, pause_irq_o, resume_irq_o, special_irq_o;
  int         fails, comparisons, cycles;
  localparam logic [11:0] E_ERRF = 12'h200, E_ERRH = 12'h100, E_CHAR = 12'h080, E_RES = 12'h040;
  localparam logic [11:0] E_PAU = 12'h020, E_SPC = 12'h010, E_LOAD = 12'h400, E_ISR = 12'h800;
  localparam logic [4:0] SAMP_TAB [4] = '{SAMP_16X, SAMP_8X, SAMP_4X, SAMP_4X};
  uefc_top DUT (.mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .isr_rd_i, .rdata_o, .evt_i, .fifo_en_i,
    .rx_count_i, .tx_count_i, .rx_pin_i, .rx_second_i, .tx_brg_o, .rx_brg_o, .tx_samp_o, .rx_samp_o,
    .send_now_o, .ir_rx_o, .dir_n_o, .tx_irq_o, .lsr_irq_o, .pause_irq_o, .resume_irq_o, .special_irq_o,
    .seq_pause_o, .seq_resume_o);
  uefc_core_model #(.BIT_CLKS(4)) u_core (.mclk_i, .rstn_i, .load_i(load), .rx_ev_i(rx_ev),
    .evt_o(evt_i), .tx_count_o(tx_count_i), .rx_count_o(rx_count_i));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // hang guard; the run needs well under a thousand cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_sim();
    end
  end
  // ============================================================
  // access tasks
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    `CHK("rdata", e, rdata_o)
  endtask
  // one-cycle event pulse: receive events, a byte load, a status read
  task automatic ev(input logic [11:0] m);
    @(posedge mclk_i);
    rx_ev    <= uefc_evt_s'(m[9:0]);
    load     <= m[10];
    isr_rd_i <= m[11];
    @(posedge mclk_i);
    rx_ev    <= '0;
    load     <= 1'b0;
    isr_rd_i <= 1'b0;
    #1;
  endtask
  task automatic fc(input logic [7:0] d);
    wr(ADDR_LINE_CTL, LCR_ENH_KEY);
    wr(ADDR_FEATURE, d);
    wr(ADDR_LINE_CTL, 8'h80);
  endtask
  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ============================================================
  // tests
  initial begin
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    tick(2);
    `CHK("samp", SAMP_16X, rx_samp_o)
    `CHK("brg", {8'h00, RST_DIV_LOW, 6'h00}, tx_brg_o)
    `CHK("dir", 1'b1, dir_n_o)
    $display("test reset done");
    wr(ADDR_LINE_CTL, 8'h80);
    wr(ADDR_DIV_FRAC, 8'h10);
    tick(1);
    `CHK("samp", SAMP_16X, rx_samp_o)
    wr(ADDR_LINE_CTL, LCR_ENH_KEY);
    wr(ADDR_ENH_FEAT, 8'h10);
    wr(ADDR_LINE_CTL, 8'h80);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DIV_FRAC, 8'(i * 16));
      tick(1);
      `CHK("tx_samp", SAMP_TAB[i], tx_samp_o)
      `CHK("rx_samp", SAMP_TAB[i], rx_samp_o)
    end
    // same fraction twice so old or new steering gives one answer
    wr(ADDR_DIV_LOW, 8'h05);
    wr(ADDR_DIV_FRAC, 8'h47);
    wr(ADDR_DIV_FRAC, 8'h47);
    wr(ADDR_DIV_LOW, 8'h22);
    wr(ADDR_DIV_HIGH, 8'h33);
    wr(ADDR_DIV_FRAC, 8'hC7);
    wr(ADDR_DIV_FRAC, 8'hC5);
    wr(ADDR_DIV_LOW, 8'h44);
    wr(ADDR_DIV_FRAC, 8'h85);
    wr(ADDR_DIV_LOW, 8'h99);
    tick(1);
    `CHK("tx_brg", {8'h33, 8'h22, 6'h07}, tx_brg_o)
    `CHK("rx_brg", {8'h00, 8'h44, 6'h05}, rx_brg_o)
    // enhanced enable cleared: the fraction control stays latched
    wr(ADDR_LINE_CTL, LCR_ENH_KEY);
    wr(ADDR_ENH_FEAT, 8'h00);
    wr(ADDR_LINE_CTL, 8'h80);
    wr(ADDR_DIV_FRAC, 8'h20);
    rd(ADDR_DIV_FRAC, 8'h85);
    $display("test baud done");
    repeat (3) ev(E_CHAR);
    ev(E_LOAD);
    ev(E_LOAD);
    wr(ADDR_LINE_CTL, LCR_ENH_KEY);
    wr(ADDR_FEATURE, 8'h80);
    rd(ADDR_FEATURE, 8'h80);
    rd(ADDR_SCRATCH, 8'h01);
    wr(ADDR_FEATURE, 8'h00);
    rd(ADDR_SCRATCH, 8'h03);
    fc(8'h40);
    rd(ADDR_SCRATCH, 8'h03);
    fc(8'h00);
    rd(ADDR_SCRATCH, RST_SCRATCH);
    wr(ADDR_SCRATCH, 8'h5A);
    rd(ADDR_SCRATCH, 8'h5A);
    $display("test count done");
    fc(8'h40);
    wr(ADDR_SCRATCH, 8'h00);
    ev(E_PAU);
    `CHK("pause", 1'b1, pause_irq_o)
    ev(E_RES);
    `CHK("pause_resume", 2'b01, {pause_irq_o, resume_irq_o})
    ev(E_SPC);
    ev(E_CHAR);
    `CHK("special", 1'b0, special_irq_o)
    ev(E_ISR);
    `CHK("resume", 1'b0, resume_irq_o)
    wr(ADDR_SCRATCH, 8'h80);
    ev(E_PAU);
    ev(E_RES);
    ev(E_SPC);
    ev(E_CHAR);
    `CHK("flags", 2'b11, {pause_irq_o, special_irq_o})
    ev(E_ISR);
    `CHK("flags", 3'b000, {pause_irq_o, special_irq_o, resume_irq_o})
    wr(ADDR_SCRATCH, 8'h00);
    ev(E_ERRF);
    `CHK("lsr", 1'b0, lsr_irq_o)
    ev(E_ERRH);
    `CHK("lsr", 1'b1, lsr_irq_o)
    ev(E_ISR);
    `CHK("lsr", 1'b0, lsr_irq_o)
    wr(ADDR_SCRATCH, 8'h40);
    ev(E_ERRF);
    `CHK("lsr", 1'b1, lsr_irq_o)
    // a set meeting the status read in one cycle wins
    ev(E_PAU | E_ISR);
    `CHK("set_wins", 2'b10, {pause_irq_o, lsr_irq_o})
    // first half, then its partner, then a lone second half
    ev(E_CHAR | E_PAU);
    @(posedge mclk_i);
    rx_second_i <= 1'b1;
    ev(E_CHAR | E_PAU);
    `CHK("seq_pair", 2'b10, {seq_pause_o, seq_resume_o})
    ev(E_CHAR | E_PAU);
    `CHK("seq_lone", 2'b00, {seq_pause_o, seq_resume_o})
    @(posedge mclk_i);
    rx_second_i <= 1'b0;
    $display("test interrupt done");
    fc(8'h48);
    wr(ADDR_SCRATCH, 8'h00);
    ev(E_LOAD);
    tick(3);
    `CHK("dir_irq", 2'b00, {dir_n_o, tx_irq_o})
    tick(55);
    `CHK("dir_irq", 2'b11, {dir_n_o, tx_irq_o})
    wr(ADDR_SCRATCH, 8'h08);
    ev(E_LOAD);
    tick(3);
    `CHK("dir_inv", 1'b1, dir_n_o)
    tick(55);
    `CHK("dir_inv", 1'b0, dir_n_o)
    wr(ADDR_SCRATCH, 8'h04);
    tick(1);
    `CHK("send_now", 1'b1, send_now_o)
    ev(E_LOAD);
    tick(55);
    `CHK("send_now", 1'b0, send_now_o)
    fc(8'h40);
    ev(E_LOAD);
    tick(3);
    `CHK("tx_irq", 1'b1, tx_irq_o)
    $display("test direction done");
    fc(8'h44);
    tick(1);
    `CHK("ir_rx", 1'b0, ir_rx_o)
    @(posedge mclk_i);
    rx_pin_i <= 1'b0;
    tick(2);
    `CHK("ir_rx", 1'b1, ir_rx_o)
    $display("test infrared done");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
